// [logic/psam_pkg.sv]
/*
 * Shared constants and types of the program space access mapper.
 * Assumes a 16-bit data path and a 24-bit program memory word.
 */
package psam_pkg;
   // ==========================================================
   // Widths
   localparam int DATA_W = 16;
   localparam int PADDR_W = 24;
   localparam int PWORD_W = 24;
   localparam int PAGE_W = 8;
   localparam int REMAP_LOW_W = 15;
   // ==========================================================
   // Register byte offsets
   localparam logic [3:0] OFS_TABLE_PAGE = 4'h0;
   localparam logic [3:0] OFS_REMAP_PAGE = 4'h4;
   localparam logic [3:0] OFS_CORE_CTRL = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;
   // ==========================================================
   // Field positions
   localparam int TABLE_SPACE_BIT = 7;
   localparam int VIS_ENABLE_BIT = 2;
   localparam int EA_TOP_BIT = 15;
   // ==========================================================
   // Reset values
   localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
   localparam logic [7:0] REMAP_PAGE_RST = 8'h00;
   localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
   // ==========================================================
   // Operations
   typedef enum logic [2:0] {
      PSAM_OP_DATA,
      PSAM_OP_READ_LOW,
      PSAM_OP_READ_HIGH,
      PSAM_OP_WRITE_LOW,
      PSAM_OP_WRITE_HIGH
   } psam_op_t;
endpackage : psam_pkg

// [logic/psam_mem_if.sv]
/*
 * Program memory port bundle between the mapper core and its port stage.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
interface psam_mem_if;
   logic req;
   logic wr;
   logic high_lane;
   logic [23:0] addr;
   logic [15:0] wdata;
   logic [23:0] rdata;
   logic rvalid;
   modport core (output req, output wr, output high_lane, output addr, output wdata,
      input rdata, input rvalid);
   modport port (input req, input wr, input high_lane, input addr, input wdata,
      output rdata, output rvalid);
endinterface : psam_mem_if

// [logic/psam_mem_port.sv]
/*
 * Registered program memory port stage: drives the memory array pins from flops
 * and returns read data one cycle after the array answers.
 * Assumes the array returns read data one cycle after a read request.
 */
`timescale 1ns/1ns
module psam_mem_port (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Core side
   psam_mem_if.port core,
   // Array side
   output logic pm_req,
   output logic pm_wr,
   output logic pm_high_lane,
   output logic [23:0] pm_addr,
   output logic [15:0] pm_wdata,
   input wire logic [23:0] pm_rdata
);
   logic rd_pend;
   logic rd_pend2;

   // ==========================================================
   // Request flops
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pm_req <= 1'b0;
         pm_wr <= 1'b0;
         pm_high_lane <= 1'b0;
         pm_addr <= 24'h000000;
         pm_wdata <= 16'h0000;
         rd_pend <= 1'b0;
         rd_pend2 <= 1'b0;
      end else begin
         pm_req <= core.req;
         pm_wr <= core.wr;
         pm_high_lane <= core.high_lane;
         pm_addr <= core.addr;
         pm_wdata <= core.wdata;
         rd_pend <= core.req & ~core.wr;
         rd_pend2 <= rd_pend;
      end
   end

   // ==========================================================
   // Return data
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         core.rdata <= 24'h000000;
         core.rvalid <= 1'b0;
      end else begin
         core.rvalid <= rd_pend2;
         if (rd_pend2) begin
            core.rdata <= pm_rdata;
         end
      end
   end
endmodule : psam_mem_port

// [logic/psam_reg_slave.sv]
/*
 * Avalon-MM register slave of the mapper: page registers, core control and status.
 * Assumes a master that holds each request until waitrequest is low.
 */
`timescale 1ns/1ns
module psam_reg_slave (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Register values
   output logic [7:0] table_access_page,
   output logic [7:0] remap_window_page,
   output logic [15:0] core_control_reg,
   input wire logic [7:0] status_bits
);
   logic done;
   wire logic access = (avs_read | avs_write) & ~done;
   wire logic hit_tp = avs_address == psam_pkg::OFS_TABLE_PAGE;
   wire logic hit_rp = avs_address == psam_pkg::OFS_REMAP_PAGE;
   wire logic hit_cc = avs_address == psam_pkg::OFS_CORE_CTRL;
   wire logic hit_st = avs_address == psam_pkg::OFS_STATUS;
   // A write lands at the edge where the master sees waitrequest low
   wire logic do_wr = avs_write & done;
   wire logic [31:0] rd_mux = hit_tp ? {24'h000000, table_access_page} :
      hit_rp ? {24'h000000, remap_window_page} :
      hit_cc ? {16'h0000, core_control_reg} :
      hit_st ? {24'h000000, status_bits} : 32'h00000000;

   // ==========================================================
   // One wait cycle, then answer
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         done <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         done <= access;
         avs_waitrequest <= ~access;
         if (avs_read & access) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         table_access_page <= psam_pkg::TABLE_PAGE_RST;
         remap_window_page <= psam_pkg::REMAP_PAGE_RST;
         core_control_reg <= psam_pkg::CORE_CTRL_RST;
      end else if (do_wr) begin
         if (hit_tp & avs_byteenable[0]) table_access_page <= avs_writedata[7:0];
         if (hit_rp & avs_byteenable[0]) remap_window_page <= avs_writedata[7:0];
         if (hit_cc & avs_byteenable[0]) core_control_reg[7:0] <= avs_writedata[7:0];
         if (hit_cc & avs_byteenable[1]) core_control_reg[15:8] <= avs_writedata[15:8];
      end
   end
endmodule : psam_reg_slave

// [logic/psam_mapper.sv]
/*
 * Program space access mapper: turns 16-bit data-side operands into program memory
 * addresses for table operations and the read-only remap window, and shapes the
 * returned program word into a 16-bit data word.
 * Assumes the CPU holds an operation until op_done and issues one at a time.
 */
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
// Functional notes
// - table address is table page above the full 16-bit effective address
// - table page bit 7 picks user (0) or configuration (1) space
// - remap address is remap page above low 15 address bits when top bit set
// - remap accesses force program address bit 23 to zero
// - remap ignores address bit 15; remap page bit 0 supplies it
// - remap path is read-only and returns only the low 16-bit word
// - bit 0 of every program word address is held at zero
// - table operations accept odd addresses for byte access
// - table reads may target configuration space
// - word-mode low read returns program bits 15..0
// - byte-mode low read returns selected byte of low word in bits 7..0
// - word-mode high read returns bits 23..16, data bits 15..8 zero
// - byte-mode high read returns zero for the phantom upper byte
// - high table operations are the only path to upper program byte
// - addresses step by two per program word; low and high lanes side by side
// - remap is active only while core control visibility bit 2 is set
`timescale 1ns/1ns
module psam_mapper (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // CPU data path
   input wire logic op_valid,
   input wire psam_pkg::psam_op_t op_kind,
   input wire logic op_byte,
   input wire logic [15:0] op_ea,
   input wire logic [15:0] op_wdata,
   output logic op_done,
   output logic op_remapped,
   output logic [15:0] op_rdata,
   output logic op_config_space,
   // Program memory array
   output logic pm_req,
   output logic pm_wr,
   output logic pm_high_lane,
   output logic [23:0] pm_addr,
   output logic [15:0] pm_wdata,
   input wire logic [23:0] pm_rdata
);
   typedef enum logic [1:0] {
      PSAM_IDLE,
      PSAM_WAIT,
      PSAM_FINISH
   } psam_state_t;

   psam_state_t state;
   psam_state_t next_state;
   psam_mem_if mem ();
   logic [7:0] table_access_page;
   logic [7:0] remap_window_page;
   logic [15:0] core_control_reg;
   logic [7:0] status_bits;
   logic [15:0] ea_q;
   logic byte_q;
   psam_pkg::psam_op_t kind_q;
   logic wr_pend;
   logic req_q;
   logic wr_q;
   logic high_q;
   logic [23:0] addr_q;
   logic [15:0] wdata_q;
   logic [7:0] op_count;

   // ==========================================================
   // Registers
   psam_reg_slave u_regs (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .table_access_page(table_access_page),
      .remap_window_page(remap_window_page),
      .core_control_reg(core_control_reg),
      .status_bits(status_bits)
   );

   // ==========================================================
   // Address construction
   function automatic logic [23:0] table_addr(input logic [7:0] page, input logic [15:0] ea);
      table_addr = {page, ea[15:1], 1'b0};
   endfunction : table_addr

   function automatic logic [23:0] remap_addr(input logic [7:0] page, input logic [15:0] ea);
      remap_addr = {1'b0, page, ea[14:1], 1'b0};
   endfunction : remap_addr

   wire logic vis_en = core_control_reg[psam_pkg::VIS_ENABLE_BIT];
   wire logic is_table = op_kind != psam_pkg::PSAM_OP_DATA;
   wire logic is_remap = ~is_table & vis_en & op_ea[psam_pkg::EA_TOP_BIT];
   wire logic is_write = op_kind == psam_pkg::PSAM_OP_WRITE_LOW || op_kind == psam_pkg::PSAM_OP_WRITE_HIGH;
   wire logic is_high = op_kind == psam_pkg::PSAM_OP_READ_HIGH || op_kind == psam_pkg::PSAM_OP_WRITE_HIGH;
   // A request still held while op_done stands is the finished one, not a new one
   wire logic take = (state == PSAM_IDLE) & op_valid & ~op_done;
   wire logic start = take & (is_table | is_remap);
   wire logic pass = take & ~is_table & ~is_remap;
   wire logic [23:0] next_addr = is_table ? table_addr(table_access_page, op_ea) :
      remap_addr(remap_window_page, op_ea);
   // Byte writes place the byte on the lane half chosen by address bit 0
   wire logic [15:0] next_wdata = ~op_byte ? op_wdata :
      op_ea[0] ? {op_wdata[7:0], 8'h00} : {8'h00, op_wdata[7:0]};

   // ==========================================================
   // Read data shaping
   wire logic [23:0] rw = mem.rdata;
   wire logic [7:0] low_byte = ea_q[0] ? rw[15:8] : rw[7:0];
   wire logic [7:0] high_byte = (byte_q & ea_q[0]) ? 8'h00 : rw[23:16];
   wire logic [15:0] shaped =
      (kind_q == psam_pkg::PSAM_OP_READ_HIGH) ? {8'h00, high_byte} :
      (kind_q == psam_pkg::PSAM_OP_READ_LOW && byte_q) ? {8'h00, low_byte} :
      rw[15:0];

   // ==========================================================
   // Sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         PSAM_IDLE: begin
            if (start) next_state = is_write ? PSAM_FINISH : PSAM_WAIT;
            else if (pass) next_state = PSAM_FINISH;
         end
         PSAM_WAIT: begin
            if (mem.rvalid) next_state = PSAM_FINISH;
         end
         PSAM_FINISH: begin
            next_state = PSAM_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) state <= PSAM_IDLE;
      else state <= next_state;
   end

   // ==========================================================
   // Memory request, one cycle per table or remap operation
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_q <= 1'b0;
         wr_q <= 1'b0;
         high_q <= 1'b0;
         addr_q <= 24'h000000;
         wdata_q <= 16'h0000;
      end else begin
         req_q <= start;
         wr_q <= start & is_write;
         if (start) begin
            high_q <= is_high;
            addr_q <= next_addr;
            wdata_q <= next_wdata;
         end
      end
   end

   assign mem.req = req_q;
   assign mem.wr = wr_q;
   assign mem.high_lane = high_q;
   assign mem.addr = addr_q;
   assign mem.wdata = wdata_q;

   psam_mem_port u_port (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .core(mem.port),
      .pm_req(pm_req),
      .pm_wr(pm_wr),
      .pm_high_lane(pm_high_lane),
      .pm_addr(pm_addr),
      .pm_wdata(pm_wdata),
      .pm_rdata(pm_rdata)
   );

   // ==========================================================
   // Operation capture
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ea_q <= 16'h0000;
         byte_q <= 1'b0;
         kind_q <= psam_pkg::PSAM_OP_DATA;
         wr_pend <= 1'b0;
      end else if (take) begin
         ea_q <= op_ea;
         byte_q <= op_byte;
         kind_q <= is_remap ? psam_pkg::PSAM_OP_DATA : op_kind;
         wr_pend <= is_write;
      end
   end

   // ==========================================================
   // Answer to the CPU
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         op_done <= 1'b0;
         op_remapped <= 1'b0;
         op_rdata <= 16'h0000;
         op_config_space <= 1'b0;
      end else begin
         op_done <= (state == PSAM_FINISH) & ~op_done;
         if (start) begin
            op_remapped <= is_remap;
            op_config_space <= is_table & table_access_page[psam_pkg::TABLE_SPACE_BIT];
         end else if (pass) begin
            op_remapped <= 1'b0;
            op_config_space <= 1'b0;
         end
         if (state == PSAM_WAIT && mem.rvalid) begin
            op_rdata <= shaped;
         end else if (pass || (start && is_write)) begin
            op_rdata <= 16'h0000;
         end
      end
   end

   // ==========================================================
   // Status: visibility, last space, operation count
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) op_count <= 8'h00;
      else if (start) op_count <= op_count + 8'h01;
   end

   assign status_bits = {op_count[4:0], wr_pend, op_config_space, vis_en};
endmodule : psam_mapper

// [sim/psam_mapper_checker.sv]
/* Port assertions of the program space access mapper.
   Assumes binding to psam_mapper and a CPU that holds each operation until op_done. */
`timescale 1ns/1ns
module psam_mapper_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // CPU side
   input wire logic op_valid,
   input wire psam_pkg::psam_op_t op_kind,
   input wire logic op_byte,
   input wire logic [15:0] op_ea,
   input wire logic op_done,
   input wire logic [15:0] op_rdata,
   // Array side
   input wire logic pm_req,
   input wire logic pm_wr,
   input wire logic pm_high_lane,
   input wire logic [23:0] pm_addr
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire is_data = op_kind == psam_pkg::PSAM_OP_DATA;
   wire is_rh = op_kind == psam_pkg::PSAM_OP_READ_HIGH;
   wire is_hi = is_rh || op_kind == psam_pkg::PSAM_OP_WRITE_HIGH;
   wire is_rd = is_rh || op_kind == psam_pkg::PSAM_OP_READ_LOW;
   // ==========================================================
   // Properties
   property p_align; pm_req |-> !pm_addr[0]; endproperty
   a_align: assert property (p_align) else $error("odd program address");
   property p_table_ea; op_valid && !is_data && pm_req |-> pm_addr[15:1] == op_ea[15:1]; endproperty
   a_table_ea: assert property (p_table_ea) else $error("table address mismatch");
   property p_remap_user; op_valid && is_data && pm_req |-> !pm_addr[23] && !pm_wr; endproperty
   a_remap_user: assert property (p_remap_user) else $error("remap left user space");
   property p_refuse; op_valid && is_data && !op_ea[15] |-> !pm_req; endproperty
   a_refuse: assert property (p_refuse) else $error("lower data address remapped");
   property p_lane; op_valid && pm_req |-> pm_high_lane == is_hi; endproperty
   a_lane: assert property (p_lane) else $error("wrong lane");
   property p_phantom_w; op_done && op_valid && is_rh && !op_byte |-> op_rdata[15:8] == 8'h00; endproperty
   a_phantom_w: assert property (p_phantom_w) else $error("phantom byte not zero");
   property p_phantom_b; op_done && op_valid && is_rh && op_byte && op_ea[0] |-> op_rdata == 16'h0000; endproperty
   a_phantom_b: assert property (p_phantom_b) else $error("phantom byte read nonzero");
   property p_byte; op_done && op_valid && is_rd && op_byte |-> op_rdata[15:8] == 8'h00; endproperty
   a_byte: assert property (p_byte) else $error("byte read upper bits set");
   property p_rd_done; $rose(pm_req) && !pm_wr |-> ##[3:5] op_done; endproperty
   a_rd_done: assert property (p_rd_done) else $error("read never returned");
endmodule : psam_mapper_checker

// [sim/psam_pm_model.sv]
/* Program memory array model with one-cycle read latency.
   Contents follow a fixed formula of the word address; writes are not stored. */
`timescale 1ns/1ns
module psam_pm_model (
   // Clock
   input wire logic sys_clk,
   // Array port
   input wire logic pm_req,
   input wire logic pm_wr,
   input wire logic [23:0] pm_addr,
   output logic [23:0] pm_rdata
);
   initial pm_rdata = 24'h3c3c3c;
   // Data stands one cycle after a read, otherwise the bus keeps toggling
   always @(posedge sys_clk) begin
      if (pm_req && !pm_wr) begin
         pm_rdata <= {pm_addr[8:1] ^ pm_addr[23:16], pm_addr[16:1] ^ 16'h5ac3};
      end else begin
         pm_rdata <= ~pm_rdata;
      end
   end
endmodule : psam_pm_model

// [sim/psam_mapper_tb.sv]
/* Self-checking bench of the mapper: register bus, table and remap operations.
   Assumes psam_pm_model as the program memory array. */
`timescale 1ns/1ns
module psam_mapper_tb;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic op_valid = 1'b0;
   psam_pkg::psam_op_t op_kind = psam_pkg::PSAM_OP_DATA;
   logic op_byte = 1'b0;
   logic [15:0] op_ea = 16'h0;
   logic [15:0] op_wdata = 16'h0;
   logic op_done, op_remapped, op_config_space, pm_req, pm_wr, pm_high_lane, seen_wr, seen_lane;
   logic [15:0] op_rdata, pm_wdata, seen_wdata;
   logic last_w = 1'b0;
   logic last_c = 1'b0;
   int starts = 0;
   logic [23:0] pm_addr, pm_rdata, seen_addr;
   logic [7:0] tpage = 8'h00;
   logic [7:0] rpage = 8'h00;
   logic vis = 1'b0;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int reqs = 0;

   always #50 sys_clk = ~sys_clk;

   psam_mapper dut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .op_valid(op_valid), .op_kind(op_kind),
      .op_byte(op_byte), .op_ea(op_ea), .op_wdata(op_wdata), .op_done(op_done), .op_remapped(op_remapped),
      .op_rdata(op_rdata), .op_config_space(op_config_space), .pm_req(pm_req), .pm_wr(pm_wr),
      .pm_high_lane(pm_high_lane), .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata));
   psam_pm_model u_pm (.sys_clk(sys_clk), .pm_req(pm_req), .pm_wr(pm_wr), .pm_addr(pm_addr), .pm_rdata(pm_rdata));

   // Records every array request and cuts a hang short
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (pm_req === 1'b1) begin
         reqs <= reqs + 1;
         seen_addr <= pm_addr;
         seen_wr <= pm_wr;
         seen_lane <= pm_high_lane;
         seen_wdata <= pm_wdata;
      end
      if (cycles == 20000) begin
         errors = errors + 1;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      if (errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      check(avs_waitrequest, 0);
      if (!wr) check(avs_readdata, exp);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic set_regs(input logic [7:0] t, input logic [7:0] r, input logic v);
      bus(1, psam_pkg::OFS_TABLE_PAGE, {24'h0, t}, 0);
      bus(1, psam_pkg::OFS_REMAP_PAGE, {24'h0, r}, 0);
      bus(1, psam_pkg::OFS_CORE_CTRL, {29'h0, v, 2'b00}, 0);
      tpage = t;
      rpage = r;
      vis = v;
      bus(0, psam_pkg::OFS_TABLE_PAGE, 0, {24'h0, tpage});
      bus(0, psam_pkg::OFS_REMAP_PAGE, 0, {24'h0, rpage});
      bus(0, psam_pkg::OFS_CORE_CTRL, 0, {29'h0, vis, 2'b00});
   endtask : set_regs

   task automatic run_op(input psam_pkg::psam_op_t k, input logic b, input logic [15:0] ea);
      logic [23:0] a, w;
      logic [15:0] exp, wd, wexp;
      logic acc, hi, wrk;
      int n, r0;
      acc = 1'b1;
      hi = k == psam_pkg::PSAM_OP_READ_HIGH || k == psam_pkg::PSAM_OP_WRITE_HIGH;
      wrk = k == psam_pkg::PSAM_OP_WRITE_LOW || k == psam_pkg::PSAM_OP_WRITE_HIGH;
      a = {tpage, ea[15:1], 1'b0};
      if (k == psam_pkg::PSAM_OP_DATA) begin
         acc = ea[15] && vis;
         a = {1'b0, rpage, ea[14:1], 1'b0};
      end
      w = {a[8:1] ^ a[23:16], a[16:1] ^ 16'h5ac3};
      exp = 16'h0;
      if (k == psam_pkg::PSAM_OP_READ_LOW) exp = !b ? w[15:0] : {8'h00, ea[0] ? w[15:8] : w[7:0]};
      if (k == psam_pkg::PSAM_OP_READ_HIGH) exp = (b && ea[0]) ? 16'h0 : {8'h00, w[23:16]};
      if (k == psam_pkg::PSAM_OP_DATA && acc) exp = w[15:0];
      wd = 16'($urandom);
      wexp = !b ? wd : ea[0] ? {wd[7:0], 8'h00} : {8'h00, wd[7:0]};
      r0 = reqs;
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_byte <= b;
      op_ea <= ea;
      op_wdata <= wd;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (op_done !== 1'b1 && n < 20);
      check(op_done, 1);
      check(op_rdata, exp);
      if (k == psam_pkg::PSAM_OP_DATA) check(op_remapped, acc);
      else check(op_config_space, tpage[7]);
      @(posedge sys_clk);
      op_valid <= 1'b0;
      // A write is answered before its array request has been recorded
      @(negedge sys_clk);
      check(reqs != r0, acc);
      if (acc) begin
         check(seen_addr, a);
         check(seen_lane, hi);
         check(seen_wr, wrk);
         if (wrk) check(seen_wdata, wexp);
      end
      if (acc) starts++;
      last_w = wrk;
      last_c = k != psam_pkg::PSAM_OP_DATA && tpage[7];
   endtask : run_op

   initial begin
      void'($urandom(32'h6717));
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      bus(0, psam_pkg::OFS_TABLE_PAGE, 0, {24'h0, psam_pkg::TABLE_PAGE_RST});
      bus(0, psam_pkg::OFS_REMAP_PAGE, 0, {24'h0, psam_pkg::REMAP_PAGE_RST});
      bus(0, psam_pkg::OFS_CORE_CTRL, 0, {16'h0, psam_pkg::CORE_CTRL_RST});
      bus(0, psam_pkg::OFS_STATUS, 0, 0);
      // Unmapped place ignores writes and reads zero
      bus(1, 4'h2, 32'hffffffff, 0);
      bus(0, 4'h2, 0, 0);
      for (int g = 0; g < 12; g++) begin
         set_regs(8'($urandom), 8'($urandom), g[0]);
         for (int i = 0; i < 10; i++) begin
            run_op(psam_pkg::psam_op_t'(i % 5), 1'($urandom), 16'($urandom));
         end
         bus(0, psam_pkg::OFS_STATUS, 0, {24'h0, 5'(starts), last_w, last_c, vis});
      end
      // Reset in mid-run brings registers and status back to their defaults
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      bus(0, psam_pkg::OFS_TABLE_PAGE, 0, {24'h0, psam_pkg::TABLE_PAGE_RST});
      bus(0, psam_pkg::OFS_CORE_CTRL, 0, {16'h0, psam_pkg::CORE_CTRL_RST});
      bus(0, psam_pkg::OFS_STATUS, 0, 0);
      wrap_up();
   end
endmodule : psam_mapper_tb

bind psam_mapper psam_mapper_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid),
   .op_kind(op_kind), .op_byte(op_byte), .op_ea(op_ea), .op_done(op_done), .op_rdata(op_rdata),
   .pm_req(pm_req), .pm_wr(pm_wr), .pm_high_lane(pm_high_lane), .pm_addr(pm_addr));
